// file: hw/dbs_ctl.sv
`timescale 1ns/1ps
module dbs_fifo #(
    parameter int WIDTH = dbs_pkg::CMD_W,
    parameter int DEPTH = dbs_pkg::FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    logic [PW:0] cnt_nxt;
    logic ready_r;
    logic nempty_r;
    logic push;
    logic pop;

    assign push = i_in_valid & ready_r;
    assign pop = i_out_ready & nempty_r;
    assign cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b1;
            nempty_r <= 1'b0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
            end
            if (pop) begin
                rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
            end
            cnt_r <= cnt_nxt;
            ready_r <= (cnt_nxt != (PW+1)'(DEPTH));
            nempty_r <= (cnt_nxt != '0);
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wp_r] <= i_in_data;
        end
    end

    assign o_in_ready = ready_r;
    assign o_out_valid = nempty_r;
    assign o_out_data = mem[rp_r];
endmodule : dbs_fifo

module dbs_ctl (
    dbs_if.ctl lnk,
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic i_req_write,
    input wire logic [dbs_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [dbs_pkg::DATA_W-1:0] i_req_wdata0,
    input wire logic [dbs_pkg::DATA_W-1:0] i_req_wdata1,
    input wire logic [dbs_pkg::LANES-1:0] i_req_lane0_n,
    input wire logic [dbs_pkg::LANES-1:0] i_req_lane1_n,
    output logic o_rd_valid,
    output logic [dbs_pkg::DATA_W-1:0] o_rd_data0,
    output logic [dbs_pkg::DATA_W-1:0] o_rd_data1
);
    localparam int RS_W = 3 + dbs_pkg::DATA_W;
    logic [dbs_pkg::CMD_W-1:0] cmd;
    logic cmd_valid;
    logic pop;
    logic c_wr;
    logic [dbs_pkg::ADDR_W-1:0] c_addr;
    logic [dbs_pkg::DATA_W-1:0] c_d0;
    logic [dbs_pkg::DATA_W-1:0] c_d1;
    logic [dbs_pkg::LANES-1:0] c_b0;
    logic [dbs_pkg::LANES-1:0] c_b1;
    logic [dbs_pkg::PH_W-1:0] ph_r;
    logic [dbs_pkg::PH_W-1:0] ph_nxt;
    logic k_r;
    logic kn_r;
    logic load_n_r;
    logic rw_r;
    logic [dbs_pkg::ADDR_W-1:0] addr_r;
    logic [dbs_pkg::DATA_W-1:0] dq_r;
    logic dq_oe_r;
    logic [dbs_pkg::LANES-1:0] lane_sel_r;
    logic [1:0] turn_r;
    dbs_pkg::dbs_host_state_t st_r;
    logic wr1_pend_r;
    logic [dbs_pkg::DATA_W-1:0] hold_d0_r;
    logic [dbs_pkg::DATA_W-1:0] hold_d1_r;
    logic [dbs_pkg::LANES-1:0] hold_b0_r;
    logic [dbs_pkg::LANES-1:0] hold_b1_r;
    logic [dbs_pkg::DATA_W-1:0] beat1_d_r;
    logic [dbs_pkg::LANES-1:0] beat1_b_r;
    logic [RS_W-1:0] rs1_r;
    logic [RS_W-1:0] rs2_r;
    logic e_s;
    logic en_s;
    logic qv_s;
    logic [dbs_pkg::DATA_W-1:0] q_s;
    logic e_d_r;
    logic en_d_r;
    logic beat_r;
    logic [dbs_pkg::DATA_W-1:0] first_r;
    logic rd_valid_r;
    logic [dbs_pkg::DATA_W-1:0] rd0_r;
    logic [dbs_pkg::DATA_W-1:0] rd1_r;

    dbs_fifo #(
        .WIDTH(dbs_pkg::CMD_W),
        .DEPTH(dbs_pkg::FIFO_DEPTH)
    ) u_cmd_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_in_valid(i_req_valid),
        .o_in_ready(o_req_ready),
        .i_in_data({i_req_write, i_req_addr, i_req_wdata0, i_req_wdata1,
                    i_req_lane0_n, i_req_lane1_n}),
        .o_out_valid(cmd_valid),
        .i_out_ready(pop),
        .o_out_data(cmd)
    );

    assign {c_wr, c_addr, c_d0, c_d1, c_b0, c_b1} = cmd;
    // a write waits out the bus turnaround after a read
    assign pop = (ph_r == dbs_pkg::CMD_PH) & cmd_valid & ~(c_wr & (turn_r != 2'h0));
    assign ph_nxt = (ph_r == dbs_pkg::PH_W'(dbs_pkg::K_CYC - 1)) ? '0 : ph_r + 3'h1;

    // link clock pair divided down from the local clock
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            // one phase before wrap, so the first true period after reset is full length
            ph_r <= dbs_pkg::PH_RESET;
            k_r <= 1'b0;
            kn_r <= 1'b1;
        end else begin
            ph_r <= ph_nxt;
            k_r <= (ph_nxt < dbs_pkg::PH_W'(dbs_pkg::K_HALF_CYC));
            kn_r <= ~(ph_nxt < dbs_pkg::PH_W'(dbs_pkg::K_HALF_CYC));
        end
    end

    // commands and word 0 change one cycle before the true rise, word 1 before the
    // complement rise, so they are steady when the memory samples them
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            load_n_r <= 1'b1;
            rw_r <= 1'b1;
            addr_r <= '0;
            dq_r <= '0;
            dq_oe_r <= 1'b0;
            lane_sel_r <= dbs_pkg::LANES_OFF;
            turn_r <= '0;
            st_r <= dbs_pkg::DBS_HOST_IDLE;
            wr1_pend_r <= 1'b0;
            hold_d0_r <= '0;
            hold_d1_r <= '0;
            hold_b0_r <= dbs_pkg::LANES_OFF;
            hold_b1_r <= dbs_pkg::LANES_OFF;
            beat1_d_r <= '0;
            beat1_b_r <= dbs_pkg::LANES_OFF;
        end else if (ph_r == dbs_pkg::CMD_PH) begin
            load_n_r <= ~pop;
            rw_r <= ~(pop & c_wr);
            addr_r <= pop ? c_addr : addr_r;
            if (pop && !c_wr) begin
                turn_r <= dbs_pkg::RD_TURN_K;
            end else if (turn_r != 2'h0) begin
                turn_r <= turn_r - 2'h1;
            end
            case (st_r)
                dbs_pkg::DBS_HOST_WRITE: begin
                    dq_r <= hold_d0_r;
                    lane_sel_r <= hold_b0_r;
                    dq_oe_r <= 1'b1;
                    wr1_pend_r <= 1'b1;
                    // word 1 gets its own stage: a write popped now refills the hold regs
                    beat1_d_r <= hold_d1_r;
                    beat1_b_r <= hold_b1_r;
                end
                default: begin
                    dq_r <= '0;
                    lane_sel_r <= dbs_pkg::LANES_OFF;
                    dq_oe_r <= 1'b0;
                    wr1_pend_r <= 1'b0;
                end
            endcase
            st_r <= (pop & c_wr) ? dbs_pkg::DBS_HOST_WRITE : dbs_pkg::DBS_HOST_IDLE;
            if (pop && c_wr) begin
                hold_d0_r <= c_d0;
                hold_b0_r <= c_b0;
                hold_d1_r <= c_d1;
                hold_b1_r <= c_b1;
            end
        end else if (ph_r == dbs_pkg::BEAT1_PH && wr1_pend_r) begin
            dq_r <= beat1_d_r;
            lane_sel_r <= beat1_b_r;
        end
    end

    // read return: echo pair, flag and data all cross through two flops
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rs1_r <= '0;
            rs2_r <= '0;
            e_d_r <= 1'b0;
            en_d_r <= 1'b0;
        end else begin
            rs1_r <= {lnk.echo_clock_out, lnk.echo_clock_out_n, lnk.output_valid_flag, lnk.dq};
            rs2_r <= rs1_r;
            e_d_r <= e_s;
            en_d_r <= en_s;
        end
    end

    assign {e_s, en_s, qv_s, q_s} = rs2_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            beat_r <= 1'b0;
            first_r <= '0;
            rd_valid_r <= 1'b0;
            rd0_r <= '0;
            rd1_r <= '0;
        end else begin
            rd_valid_r <= 1'b0;
            if (((e_s & ~e_d_r) | (en_s & ~en_d_r)) && qv_s) begin
                if (!beat_r) begin
                    first_r <= q_s;
                    beat_r <= 1'b1;
                end else begin
                    rd0_r <= first_r;
                    rd1_r <= q_s;
                    rd_valid_r <= 1'b1;
                    beat_r <= 1'b0;
                end
            end
        end
    end

    assign lnk.k = k_r;
    assign lnk.k_n = kn_r;
    assign lnk.load_strobe_n = load_n_r;
    assign lnk.rw = rw_r;
    assign lnk.addr = addr_r;
    assign lnk.byte_write_select_n = lane_sel_r;
    assign lnk.ctl_dq = dq_r;
    assign lnk.ctl_dq_oe = dq_oe_r;
    assign o_rd_valid = rd_valid_r;
    assign o_rd_data0 = rd0_r;
    assign o_rd_data1 = rd1_r;
endmodule : dbs_ctl

// file: hw/dbs_if.sv
`timescale 1ns/1ps
interface dbs_if;
    logic k;
    logic k_n;
    logic load_strobe_n;
    logic rw;
    logic [dbs_pkg::ADDR_W-1:0] addr;
    logic [dbs_pkg::LANES-1:0] byte_write_select_n;
    logic [dbs_pkg::DATA_W-1:0] ctl_dq;
    logic ctl_dq_oe;
    logic [dbs_pkg::DATA_W-1:0] mem_dq;
    logic mem_dq_oe;
    logic [dbs_pkg::DATA_W-1:0] dq;
    logic echo_clock_out;
    logic echo_clock_out_n;
    logic output_valid_flag;

    // shared pins resolved from the two enables; undriven bus reads as zero
    assign dq = mem_dq_oe ? mem_dq : (ctl_dq_oe ? ctl_dq : '0);

    modport mem (
        input k, k_n, load_strobe_n, rw, addr, byte_write_select_n, dq,
        output mem_dq, mem_dq_oe, echo_clock_out, echo_clock_out_n, output_valid_flag
    );
    modport ctl (
        output k, k_n, load_strobe_n, rw, addr, byte_write_select_n, ctl_dq, ctl_dq_oe,
        input dq, echo_clock_out, echo_clock_out_n, output_valid_flag
    );
endinterface : dbs_if

// file: hw/dbs_mem.sv
// What this block does
// - accesses start only on true clock rise
// - write data captured on both clock rises
// - read data driven on both clock rises
// - data pins float when no read active
// - data bus 18 bits wide
// - low load strobe latches address and direction
// - every access moves exactly two words
// - select high means read, low write
// - byte selects sampled per beat per lane
// - deselected bytes stay unchanged in array
// - one address bus for reads and writes
// - two equal arrays, one per burst word
// - valid flag marks read data, echo aligned
// - free-running echo clocks follow true and complement clocks
// - termination range latched at power-up
// - PLL off gives one-cycle read latency
`timescale 1ns/1ps
module dbs_mem (
    dbs_if.mem lnk,
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_pll_disable_n,
    input wire logic i_termination_range_select,
    output logic o_term_high_range
);
    localparam int SY_W = 4 + dbs_pkg::ADDR_W + dbs_pkg::LANES + dbs_pkg::DATA_W + 2;

    logic [SY_W-1:0] sy1_r;
    logic [SY_W-1:0] sy2_r;
    logic k_s;
    logic kn_s;
    logic load_n_s;
    logic rw_s;
    logic [dbs_pkg::ADDR_W-1:0] addr_s;
    logic [dbs_pkg::LANES-1:0] lane_n_s;
    logic [dbs_pkg::DATA_W-1:0] dq_s;
    logic pll_dis_n_s;
    logic term_s;
    logic k_d_r;
    logic kn_d_r;
    logic k_rise;
    logic kn_rise;
    logic any_rise;
    logic rd_cmd;
    logic wr_cmd;

    logic [dbs_pkg::DATA_W-1:0] arr0 [dbs_pkg::ARRAY_DEPTH];
    logic [dbs_pkg::DATA_W-1:0] arr1 [dbs_pkg::ARRAY_DEPTH];

    logic wr0_pend_r;
    logic wr1_pend_r;
    logic [dbs_pkg::ADDR_W-1:0] wr0_addr_r;
    logic [dbs_pkg::ADDR_W-1:0] wr1_addr_r;

    logic beat_v_r [dbs_pkg::PIPE_LEN];
    logic [dbs_pkg::DATA_W-1:0] beat_d_r [dbs_pkg::PIPE_LEN];
    logic beat_v_nxt [dbs_pkg::PIPE_LEN];
    logic [dbs_pkg::DATA_W-1:0] beat_d_nxt [dbs_pkg::PIPE_LEN];

    logic [dbs_pkg::DATA_W-1:0] dq_r;
    logic dq_oe_r;
    logic out_valid_r;
    logic echo_r;
    logic echo_n_r;
    logic [1:0] init_cnt_r;
    logic term_done_r;
    logic term_high_r;

    // keeps old bits wherever the lane select is high (not asserted)
    function automatic logic [dbs_pkg::DATA_W-1:0] lane_merge(
        input logic [dbs_pkg::DATA_W-1:0] old_w,
        input logic [dbs_pkg::DATA_W-1:0] new_w,
        input logic [dbs_pkg::LANES-1:0] sel_n
    );
        logic [dbs_pkg::DATA_W-1:0] res;
        res = old_w;
        for (int b = 0; b < dbs_pkg::LANES; b++) begin
            if (!sel_n[b]) begin
                res[b*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W] =
                    new_w[b*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W];
            end
        end
        return res;
    endfunction : lane_merge

    // every pin crosses in through two flops
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sy1_r <= '0;
            sy2_r <= '0;
        end else begin
            sy1_r <= {lnk.k, lnk.k_n, lnk.load_strobe_n, lnk.rw, lnk.addr,
                      lnk.byte_write_select_n, lnk.dq, i_pll_disable_n,
                      i_termination_range_select};
            sy2_r <= sy1_r;
        end
    end

    assign {k_s, kn_s, load_n_s, rw_s, addr_s, lane_n_s, dq_s, pll_dis_n_s, term_s} = sy2_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            k_d_r <= 1'b0;
            kn_d_r <= 1'b0;
        end else begin
            k_d_r <= k_s;
            kn_d_r <= kn_s;
        end
    end

    assign k_rise = k_s & ~k_d_r;
    assign kn_rise = kn_s & ~kn_d_r;
    assign any_rise = k_rise | kn_rise;
    assign rd_cmd = k_rise & ~load_n_s & rw_s;
    assign wr_cmd = k_rise & ~load_n_s & ~rw_s;

    // word 0 lands on the next true rise, word 1 on the complement rise after it;
    // two pending slots so back-to-back writes do not lose the second word
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr0_pend_r <= 1'b0;
            wr1_pend_r <= 1'b0;
            wr0_addr_r <= '0;
            wr1_addr_r <= '0;
        end else begin
            if (k_rise) begin
                wr0_pend_r <= wr_cmd;
                if (wr_cmd) begin
                    wr0_addr_r <= addr_s;
                end
                wr1_pend_r <= wr0_pend_r;
                wr1_addr_r <= wr0_addr_r;
            end else if (kn_rise) begin
                wr1_pend_r <= 1'b0;
            end
        end
    end

    // storage arrays carry no reset
    always_ff @(posedge i_clk) begin
        if (k_rise && wr0_pend_r) begin
            arr0[wr0_addr_r] <= lane_merge(arr0[wr0_addr_r], dq_s, lane_n_s);
        end
        if (kn_rise && wr1_pend_r) begin
            arr1[wr1_addr_r] <= lane_merge(arr1[wr1_addr_r], dq_s, lane_n_s);
        end
    end

    // beat pipeline advances one slot per half clock; slot 0 goes to the pins
    always_comb begin
        int lat;
        lat = pll_dis_n_s ? dbs_pkg::LAT_PLL : dbs_pkg::LAT_DLL;
        for (int i = 0; i < dbs_pkg::PIPE_LEN; i++) begin
            beat_v_nxt[i] = beat_v_r[i];
            beat_d_nxt[i] = beat_d_r[i];
        end
        if (any_rise) begin
            for (int i = 0; i < dbs_pkg::PIPE_LEN - 1; i++) begin
                beat_v_nxt[i] = beat_v_r[i+1];
                beat_d_nxt[i] = beat_d_r[i+1];
            end
            beat_v_nxt[dbs_pkg::PIPE_LEN-1] = 1'b0;
            beat_d_nxt[dbs_pkg::PIPE_LEN-1] = '0;
        end
        if (rd_cmd) begin
            beat_v_nxt[lat] = 1'b1;
            beat_d_nxt[lat] = arr0[addr_s];
            beat_v_nxt[lat+1] = 1'b1;
            beat_d_nxt[lat+1] = arr1[addr_s];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < dbs_pkg::PIPE_LEN; i++) begin
                beat_v_r[i] <= 1'b0;
                beat_d_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < dbs_pkg::PIPE_LEN; i++) begin
                beat_v_r[i] <= beat_v_nxt[i];
                beat_d_r[i] <= beat_d_nxt[i];
            end
        end
    end

    // pins change in the same cycle as the echo edge so both stay aligned
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dq_r <= '0;
            dq_oe_r <= 1'b0;
            out_valid_r <= 1'b0;
        end else if (any_rise) begin
            dq_r <= beat_v_nxt[0] ? beat_d_nxt[0] : '0;
            dq_oe_r <= beat_v_nxt[0];
            out_valid_r <= beat_v_nxt[0];
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            echo_r <= 1'b0;
            echo_n_r <= 1'b0;
        end else begin
            echo_r <= k_s;
            echo_n_r <= kn_s;
        end
    end

    // strap taken once, after the synchroniser has filled
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            init_cnt_r <= '0;
            term_done_r <= 1'b0;
            term_high_r <= 1'b1;
        end else if (!term_done_r) begin
            if (init_cnt_r == dbs_pkg::INIT_SETTLE) begin
                term_high_r <= term_s;
                term_done_r <= 1'b1;
            end else begin
                init_cnt_r <= init_cnt_r + 2'h1;
            end
        end
    end

    assign lnk.mem_dq = dq_r;
    assign lnk.mem_dq_oe = dq_oe_r;
    assign lnk.output_valid_flag = out_valid_r;
    assign lnk.echo_clock_out = echo_r;
    assign lnk.echo_clock_out_n = echo_n_r;
    assign o_term_high_range = term_high_r;
endmodule : dbs_mem

// file: hw/dbs_pkg.sv
package dbs_pkg;
    // narrow variant: 18-bit data bus, two 9-bit byte lanes
    localparam int DATA_W = 18;
    localparam int BYTE_W = 9;
    localparam int LANES = 2;
    localparam int ADDR_W = 19;
    localparam int ARRAY_DEPTH = 524288;
    localparam int BURST_LEN = 2;
    // link clock timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int K_PERIOD_NS = 320;
    localparam int K_CYC = K_PERIOD_NS / CLK_PERIOD_NS;
    localparam int K_HALF_CYC = K_CYC / 2;
    localparam int PH_W = 3;
    localparam logic [PH_W-1:0] PH_RESET = PH_W'(K_CYC - 1);
    localparam logic [PH_W-1:0] CMD_PH = PH_W'(K_CYC - 2);
    localparam logic [PH_W-1:0] BEAT1_PH = PH_W'(K_CYC - 2 - K_HALF_CYC);
    // read latency in half clock edges after the load edge
    localparam int LAT_PLL = 5;
    localparam int LAT_DLL = 2;
    localparam int PIPE_LEN = LAT_PLL + BURST_LEN;
    // cycles after reset release before the termination strap is sampled
    localparam logic [1:0] INIT_SETTLE = 2'h2;
    // K cycles a write waits after a read so the bus can turn around
    localparam logic [1:0] RD_TURN_K = 2'h3;
    localparam int FIFO_DEPTH = 8;
    localparam int CMD_W = 1 + ADDR_W + 2 * DATA_W + 2 * LANES;
    localparam logic [LANES-1:0] LANES_OFF = 2'h3;
    typedef enum logic [1:0] {
        DBS_HOST_IDLE = 2'h1,
        DBS_HOST_WRITE = 2'h2
    } dbs_host_state_t;
endpackage : dbs_pkg

// file: test/dbs_assertions.sv
`timescale 1ns/1ps
module dbs_chk (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic k,
    input wire logic k_n,
    input wire logic load_strobe_n,
    input wire logic rw,
    input wire logic [dbs_pkg::ADDR_W-1:0] addr,
    input wire logic ctl_dq_oe,
    input wire logic mem_dq_oe,
    input wire logic echo_clock_out,
    input wire logic echo_clock_out_n,
    input wire logic output_valid_flag
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    k_pair_a:
        assert property (k_n == !k) else $error("k pair out of step");
    k_period_a:
        assert property ($rose(k) |-> ##8 $rose(k)) else $error("k period wrong");
    load_hold_a:
        assert property ($fell(load_strobe_n) |-> (!load_strobe_n) [*8])
            else $error("load strobe not held one period");
    cmd_stable_a:
        assert property ($rose(k) |-> $stable(addr) && $stable(rw) && $stable(load_strobe_n))
            else $error("command moved at k rise");
    bus_excl_a:
        assert property (!(mem_dq_oe && ctl_dq_oe)) else $error("both ends drive data");
    valid_oe_a:
        assert property (output_valid_flag == mem_dq_oe) else $error("valid flag off bus");
    valid_echo_a:
        assert property ($changed(output_valid_flag) |->
            $changed(echo_clock_out) || $changed(echo_clock_out_n))
            else $error("valid flag not on echo edge");
    read_burst_a:
        assert property ($rose(mem_dq_oe) |-> mem_dq_oe [*8]) else $error("read burst short");
    write_burst_a:
        assert property ($rose(ctl_dq_oe) |-> ctl_dq_oe [*8]) else $error("write burst short");
    read_lat_a:
        assert property ($fell(load_strobe_n) && rw |=> ##[7:27] mem_dq_oe)
            else $error("read data late");
    echo_period_a:
        assert property ($rose(echo_clock_out) |-> ##8 $rose(echo_clock_out))
            else $error("echo clock not free running");

    cover property ($rose(output_valid_flag));
    cover property ($rose(ctl_dq_oe));
    cover property ($fell(load_strobe_n) && rw ##8 !load_strobe_n && rw);
endmodule : dbs_chk

// file: test/tb_ddr_burst2_sram_port.sv
`timescale 1ns/1ps
module tb_ddr_burst2_sram_port;
    localparam int AW = dbs_pkg::ADDR_W;
    localparam int DW = dbs_pkg::DATA_W;
    typedef struct {
        logic wr;
        logic [AW-1:0] a;
        logic [DW-1:0] d0;
        logic [DW-1:0] d1;
        logic [1:0] b0;
        logic [1:0] b1;
    } dbs_row_t;
    // read rows carry the words they should return
    dbs_row_t rows [8] = '{
        '{1'b1, 19'h00001, 18'h12345, 18'h2ABCD, 2'h0, 2'h0},
        '{1'b1, 19'h00002, 18'h0F0F0, 18'h3C3C3, 2'h0, 2'h0},
        '{1'b1, 19'h00001, 18'h3FFFF, 18'h3FFFF, 2'h2, 2'h1},
        '{1'b1, 19'h00002, 18'h00000, 18'h00000, 2'h3, 2'h3},
        '{1'b1, 19'h7FFFF, 18'h00001, 18'h20000, 2'h0, 2'h0},
        '{1'b0, 19'h00001, 18'h123FF, 18'h3FFCD, 2'h3, 2'h3},
        '{1'b0, 19'h00002, 18'h0F0F0, 18'h3C3C3, 2'h3, 2'h3},
        '{1'b0, 19'h7FFFF, 18'h00001, 18'h20000, 2'h3, 2'h3}
    };
    logic i_clk, i_resetn, pll_n, term_sel, term_hi;
    logic req_valid, req_ready, req_write, rd_valid;
    logic [AW-1:0] req_addr;
    logic [DW-1:0] wd0, wd1, rd0, rd1;
    logic [1:0] b0, b1;
    logic [2*DW-1:0] eq [$];
    logic [DW-1:0] wq [$];
    logic [2*DW-1:0] e;
    logic strobe_q = 1'b1, oe_q = 1'b0, saw_full = 1'b0;
    int failures = 0, tests_run = 0, bc = 0, lat = 0, lat_seen = 0, lat_on = 0, cyc = 0;

    dbs_if u_dbs_if ();
    dbs_mem u_dbs_mem (.lnk(u_dbs_if.mem), .i_clk(i_clk), .i_resetn(i_resetn),
        .i_pll_disable_n(pll_n), .i_termination_range_select(term_sel),
        .o_term_high_range(term_hi));
    dbs_ctl u_dbs_ctl (.lnk(u_dbs_if.ctl), .i_clk(i_clk), .i_resetn(i_resetn),
        .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_write(req_write),
        .i_req_addr(req_addr), .i_req_wdata0(wd0), .i_req_wdata1(wd1),
        .i_req_lane0_n(b0), .i_req_lane1_n(b1), .o_rd_valid(rd_valid),
        .o_rd_data0(rd0), .o_rd_data1(rd1));
    dbs_chk u_dbs_chk (.i_clk(i_clk), .i_resetn(i_resetn), .k(u_dbs_if.k),
        .k_n(u_dbs_if.k_n), .load_strobe_n(u_dbs_if.load_strobe_n), .rw(u_dbs_if.rw),
        .addr(u_dbs_if.addr), .ctl_dq_oe(u_dbs_if.ctl_dq_oe),
        .mem_dq_oe(u_dbs_if.mem_dq_oe), .echo_clock_out(u_dbs_if.echo_clock_out),
        .echo_clock_out_n(u_dbs_if.echo_clock_out_n),
        .output_valid_flag(u_dbs_if.output_valid_flag));

    always #20 i_clk = ~i_clk;

    task chk_d(input string n, input logic [2*DW-1:0] x, input logic [2*DW-1:0] s);
        tests_run++;
        if (s !== x) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask : chk_d

    task chk_b(input string n, input logic x, input logic s);
        chk_d(n, {35'h0, x}, {35'h0, s});
    endtask : chk_b

    task tally_and_finish();
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    // called right after a clock edge; valid is left high for back-to-back pushes
    task push(input dbs_row_t r);
        req_valid <= 1'b1;
        req_write <= r.wr;
        req_addr <= r.a;
        wd0 <= r.d0;
        wd1 <= r.d1;
        b0 <= r.b0;
        b1 <= r.b1;
        if (!r.wr)
            eq.push_back({r.d1, r.d0});
        @(posedge i_clk);
        while (req_ready !== 1'b1) @(posedge i_clk);
    endtask : push

    // long idle so queued writes land before a read of the same place
    task drain();
        req_valid <= 1'b0;
        @(posedge i_clk);
        while (eq.size() != 0) @(posedge i_clk);
        repeat (120) @(posedge i_clk);
    endtask : drain

    always @(posedge i_clk) begin
        cyc++;
        if (u_dbs_if.output_valid_flag === 1'b1) begin
            if (bc % 4 == 0)
                wq.push_back(u_dbs_if.dq);
            bc++;
        end else
            bc = 0;
        if (req_ready === 1'b0)
            saw_full = 1'b1;
        if (u_dbs_if.load_strobe_n === 1'b0 && strobe_q === 1'b1 && u_dbs_if.rw === 1'b1)
            lat = 0;
        else
            lat++;
        if (u_dbs_if.mem_dq_oe === 1'b1 && oe_q === 1'b0)
            lat_seen = lat;
        strobe_q = u_dbs_if.load_strobe_n;
        oe_q = u_dbs_if.mem_dq_oe;
        if (rd_valid === 1'b1) begin
            e = eq.pop_front();
            chk_d("rd_data", e, {rd1, rd0});
            chk_d("dq_word0", {18'h0, e[DW-1:0]}, {18'h0, wq.pop_front()});
            chk_d("dq_word1", {18'h0, e[2*DW-1:DW]}, {18'h0, wq.pop_front()});
        end
        if (cyc == 20000) begin
            failures++;
            tally_and_finish();
        end
    end

    initial begin
        i_clk = 1'b0;
        i_resetn = 1'b0;
        pll_n = 1'b1;
        term_sel = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        wd0 = '0;
        wd1 = '0;
        b0 = 2'h3;
        b1 = 2'h3;
        repeat (20) @(posedge i_clk);
        chk_b("term_reset", 1'b1, term_hi);
        chk_b("mem_oe_reset", 1'b0, u_dbs_if.mem_dq_oe);
        chk_b("ready_reset", 1'b1, req_ready);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            if (!rows[i].wr && rows[i - 1].wr)
                drain();
            push(rows[i]);
        end
        drain();
        $display("test table done");
        for (int i = 0; i < 10; i++)
            push('{1'b1, AW'(16 + i), DW'(i), ~DW'(i), 2'h0, 2'h0});
        drain();
        chk_b("fifo_refused", 1'b1, saw_full);
        chk_b("fifo_ready", 1'b1, req_ready);
        push('{1'b0, 19'h00010, 18'h00000, 18'h3FFFF, 2'h3, 2'h3});
        push('{1'b0, 19'h00019, 18'h00009, 18'h3FFF6, 2'h3, 2'h3});
        drain();
        $display("test fifo done");
        push(rows[5]);
        drain();
        lat_on = lat_seen;
        pll_n <= 1'b0;
        repeat (16) @(posedge i_clk);
        push(rows[5]);
        drain();
        chk_d("latency_gap", 36'(12), 36'(lat_on - lat_seen));
        pll_n <= 1'b1;
        $display("test latency done");
        term_sel <= 1'b0;
        i_resetn <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk_b("term_in_reset", 1'b1, term_hi);
        i_resetn <= 1'b1;
        repeat (6) @(posedge i_clk);
        chk_b("term_low", 1'b0, term_hi);
        push(rows[6]);
        drain();
        $display("test strap done");
        tally_and_finish();
    end
endmodule : tb_ddr_burst2_sram_port
